// ==== ast_pkg.sv ====
// constants, register map and state encodings of the async serial core
package ast_pkg;
  localparam int          ADDR_W      = 18;
  localparam int          DATA_W      = 32;
  localparam logic [15:0] IDX_MODE    = 16'hFF50;
  localparam logic [15:0] IDX_TXBUF   = 16'hFF51;
  localparam logic [15:0] IDX_RXBUF   = 16'hFF52;
  localparam logic [15:0] IDX_ERR     = 16'hFF53;
  localparam logic [15:0] IDX_AUX     = 16'hFF54;
  localparam logic [15:0] IDX_TXSTAT  = 16'hFF55;
  localparam logic [15:0] IDX_BAUD    = 16'hFF57;
  localparam logic [1:0]  IDX_LSB     = 2'b00;
  localparam logic [ADDR_W-1:0] ADDR_MODE   = {IDX_MODE, IDX_LSB};
  localparam logic [ADDR_W-1:0] ADDR_TXBUF  = {IDX_TXBUF, IDX_LSB};
  localparam logic [ADDR_W-1:0] ADDR_RXBUF  = {IDX_RXBUF, IDX_LSB};
  localparam logic [ADDR_W-1:0] ADDR_ERR    = {IDX_ERR, IDX_LSB};
  localparam logic [ADDR_W-1:0] ADDR_AUX    = {IDX_AUX, IDX_LSB};
  localparam logic [ADDR_W-1:0] ADDR_TXSTAT = {IDX_TXSTAT, IDX_LSB};
  localparam logic [ADDR_W-1:0] ADDR_BAUD   = {IDX_BAUD, IDX_LSB};

  localparam logic [7:0]  MODE_RST    = 8'h01;
  localparam logic [7:0]  ERR_RST     = 8'h00;
  localparam logic [7:0]  TXBUF_RST   = 8'hFF;
  localparam logic [7:0]  RXBUF_RST   = 8'hFF;
  localparam logic [7:0]  AUX_RST     = 8'h00;
  localparam logic [7:0]  BAUD_RST    = 8'hFF;
  localparam logic [7:0]  AUX_BREAK_MASK = 8'hC0;
  localparam logic [23:0] RD_PAD      = 24'h000000;
  localparam logic [31:0] RD_ZERO     = 32'h00000000;

  localparam int MODE_POWER = 7;
  localparam int MODE_TXE   = 6;
  localparam int MODE_RXE   = 5;
  localparam int MODE_PAR_H = 4;
  localparam int MODE_PAR_L = 3;
  localparam int MODE_CL    = 2;
  localparam int MODE_SL    = 1;
  localparam int MODE_ROUTE = 0;
  localparam int ERR_PE     = 2;
  localparam int ERR_FE     = 1;
  localparam int ERR_OVR    = 0;
  localparam int TXS_FULL   = 1;
  localparam int TXS_BUSY   = 0;

  localparam logic [1:0] PAR_NONE = 2'b00;
  localparam logic [1:0] PAR_ZERO = 2'b01;
  localparam logic [1:0] PAR_ODD  = 2'b10;
  localparam logic [1:0] PAR_EVEN = 2'b11;

  localparam logic [2:0] BIT_FIRST  = 3'd0;
  localparam logic [2:0] BIT_LAST7  = 3'd6;
  localparam logic [2:0] BIT_LAST8  = 3'd7;
  localparam logic [2:0] BIT_STEP   = 3'd1;
  localparam logic [1:0] AGE_ZERO   = 2'd0;
  localparam logic [1:0] AGE_STEP   = 2'd1;
  localparam logic [1:0] BAUD_AGE   = 2'd2;
  localparam logic [7:0] CNT_LAST   = 8'h01;
  localparam logic [7:0] CNT_STEP   = 8'h01;
  localparam logic [7:0] CNT_ZERO   = 8'h00;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_PAR   = 3'b011,
    TX_STOP1 = 3'b100,
    TX_STOP2 = 3'b101
  } ast_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100
  } ast_rx_state_t;
endpackage

// ==== ast_tmr_if.sv ====
// bit timer control bundle between the core and one bit timer
`timescale 1ns/100ps
interface ast_tmr_if;
  logic       restart;
  logic       half;
  logic       run;
  logic       base_fall;
  logic [7:0] divisor;
  logic       tick;
  modport ctrl (output restart, output half, output run, output base_fall, output divisor, input tick);
  modport tmr  (input restart, input half, input run, input base_fall, input divisor, output tick);
endinterface

// ==== ast_bit_timer.sv ====
// bit period counter clocked by ref_clk, stepped on base clock falling edges
`timescale 1ns/100ps
module ast_bit_timer
  import ast_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  ast_tmr_if.tmr   t
);
  typedef struct packed {
    logic [7:0] cnt;
  } ast_tmr_state_t;

  ast_tmr_state_t st;
  ast_tmr_state_t next_st;

  // tick only on a falling base edge so every bit change lands on that edge
  assign t.tick = t.run && t.base_fall && !t.restart && (st.cnt == CNT_LAST);

  always_comb
  begin
    next_st = st;
    if (t.restart)
    begin
      // half period first lets the receiver sample mid-bit
      next_st.cnt = t.half ? {1'b0, t.divisor[7:1]} : t.divisor;
    end
    else if (t.run && t.base_fall)
    begin
      if (st.cnt == CNT_LAST)
        next_st.cnt = t.divisor;
      else
        next_st.cnt = st.cnt - CNT_STEP;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '{cnt: CNT_ZERO};
    else
      st <= next_st;
  end
endmodule

// ==== ast_core.sv ====
// async serial transmit/receive core with apb register slave
`timescale 1ns/100ps
module ast_core
  import ast_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              base_clk,
  input  wire logic              serial_in_pin,
  output logic                   serial_out_pin,
  output logic                   tx_complete_irq,
  output logic                   rx_complete_irq,
  output logic                   rx_error_irq
);
  typedef struct packed {
    logic [7:0]      mode;
    logic [7:0]      err;
    logic [7:0]      txbuf;
    logic [7:0]      rxbuf;
    logic [7:0]      aux;
    logic [7:0]      baud;
    logic            tx_full;
    logic            tx_busy;
    logic            rx_full;
    logic [31:0]     rdata;
    logic            base_q;
    logic [1:0]      age;
    ast_tx_state_t   tx_st;
    logic [7:0]      tx_sh;
    logic [2:0]      tx_cnt;
    logic            tx_par;
    logic            tx_out;
    logic            tx_rst;
    ast_rx_state_t   rx_st;
    logic [7:0]      rx_sh;
    logic [2:0]      rx_cnt;
    logic            rx_par;
    logic            rx_pe;
    logic            rx_rst;
    logic            rx_half;
    logic            tx_done;
    logic            rx_ok;
    logic            rx_bad;
  } ast_core_state_t;

  localparam ast_core_state_t ST_RST = '{
    mode: MODE_RST, err: ERR_RST, txbuf: TXBUF_RST, rxbuf: RXBUF_RST, aux: AUX_RST, baud: BAUD_RST,
    tx_full: 1'b0, tx_busy: 1'b0, rx_full: 1'b0, rdata: RD_ZERO, base_q: 1'b0, age: AGE_ZERO,
    tx_st: TX_IDLE, tx_sh: TXBUF_RST, tx_cnt: BIT_FIRST, tx_par: 1'b0, tx_out: 1'b1, tx_rst: 1'b0,
    rx_st: RX_IDLE, rx_sh: RXBUF_RST, rx_cnt: BIT_FIRST, rx_par: 1'b0, rx_pe: 1'b0, rx_rst: 1'b0,
    rx_half: 1'b0, tx_done: 1'b0, rx_ok: 1'b0, rx_bad: 1'b0};

  ast_core_state_t st;
  ast_core_state_t next_st;

  ast_tmr_if tx_t ();
  ast_tmr_if rx_t ();

  logic       power;
  logic       tx_en;
  logic       rx_en;
  logic       base_fall;
  logic       baud_ok;
  logic       rx_line;
  logic       setup;
  logic       acc;
  logic       mapped;
  logic       wr_txbuf;
  logic       err_rd;
  logic       rx_stop_tick;
  logic [1:0] par_mode;
  logic [2:0] last_bit;

  assign power     = st.mode[MODE_POWER];
  assign tx_en     = power && st.mode[MODE_TXE];
  assign rx_en     = power && st.mode[MODE_RXE];
  assign par_mode  = {st.mode[MODE_PAR_H], st.mode[MODE_PAR_L]};
  assign last_bit  = st.mode[MODE_CL] ? BIT_LAST8 : BIT_LAST7;
  assign base_fall = st.base_q && !base_clk;
  assign baud_ok   = (st.age == BAUD_AGE);
  assign rx_line   = power ? serial_in_pin : 1'b1;
  assign setup     = psel && !penable;
  assign acc       = psel && penable;
  assign mapped    = (paddr == ADDR_MODE) || (paddr == ADDR_TXBUF) || (paddr == ADDR_RXBUF) ||
                     (paddr == ADDR_ERR) || (paddr == ADDR_AUX) || (paddr == ADDR_TXSTAT) ||
                     (paddr == ADDR_BAUD);
  assign wr_txbuf  = acc && pwrite && (paddr == ADDR_TXBUF);
  assign err_rd    = acc && !pwrite && (paddr == ADDR_ERR);
  assign rx_stop_tick = rx_en && (st.rx_st == RX_STOP) && rx_t.tick;

  // zero wait states; read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata  = st.rdata;

  assign serial_out_pin  = st.tx_out;
  assign tx_complete_irq = st.tx_done;
  assign rx_complete_irq = st.rx_ok;
  assign rx_error_irq    = st.rx_bad;

  assign tx_t.restart   = st.tx_rst;
  assign tx_t.half      = 1'b0;
  assign tx_t.run       = baud_ok && tx_en && (st.tx_st != TX_IDLE);
  assign tx_t.base_fall = base_fall;
  assign tx_t.divisor   = st.baud;
  assign rx_t.restart   = st.rx_rst;
  assign rx_t.half      = st.rx_half;
  assign rx_t.run       = baud_ok && rx_en && (st.rx_st != RX_IDLE);
  assign rx_t.base_fall = base_fall;
  assign rx_t.divisor   = st.baud;

  ast_bit_timer u_tx_tmr (.ref_clk(ref_clk), .rst_n(rst_n), .t(tx_t.tmr));
  ast_bit_timer u_rx_tmr (.ref_clk(ref_clk), .rst_n(rst_n), .t(rx_t.tmr));

  always_comb
  begin
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic       pe;
    logic       fe;
    logic       ovr;
    next_st = st;
    tx_data = st.mode[MODE_CL] ? st.txbuf : {1'b0, st.txbuf[6:0]};
    rx_data = st.mode[MODE_CL] ? st.rx_sh : {1'b0, st.rx_sh[7:1]};
    pe      = 1'b0;
    fe      = 1'b0;
    ovr     = 1'b0;
    next_st.base_q  = base_clk;
    next_st.tx_rst  = 1'b0;
    next_st.rx_rst  = 1'b0;
    next_st.rx_half = 1'b0;
    next_st.tx_done = 1'b0;
    next_st.rx_ok   = 1'b0;
    next_st.rx_bad  = 1'b0;
    if (power && base_fall && (st.age != BAUD_AGE))
      next_st.age = st.age + AGE_STEP;

    // register bus
    if (setup)
    begin
      next_st.rdata = RD_ZERO;
      case (paddr)
        ADDR_MODE:   next_st.rdata = {RD_PAD, st.mode};
        ADDR_TXBUF:  next_st.rdata = {RD_PAD, st.txbuf};
        ADDR_RXBUF:  next_st.rdata = {RD_PAD, st.rxbuf};
        ADDR_ERR:    next_st.rdata = {RD_PAD, st.err};
        ADDR_AUX:    next_st.rdata = {RD_PAD, st.aux};
        ADDR_TXSTAT: next_st.rdata = {RD_PAD, 6'b000000, st.tx_full, st.tx_busy};
        ADDR_BAUD:   next_st.rdata = {RD_PAD, st.baud};
        default:     next_st.rdata = RD_ZERO;
      endcase
    end
    if (acc && pwrite)
    begin
      case (paddr)
        ADDR_MODE:  next_st.mode = pwdata[7:0];
        ADDR_AUX:   next_st.aux  = pwdata[7:0];
        ADDR_BAUD:  next_st.baud = pwdata[7:0];
        ADDR_TXBUF:
        begin
          next_st.txbuf = pwdata[7:0];
          if (tx_en)
            next_st.tx_full = 1'b1;
        end
        default:    next_st.mode = st.mode;
      endcase
    end
    // clear first so a same-cycle error still lands
    if (err_rd)
      next_st.err = ERR_RST;
    if (acc && !pwrite && (paddr == ADDR_RXBUF))
      next_st.rx_full = 1'b0;

    // transmitter
    case (st.tx_st)
      TX_IDLE:
      begin
        next_st.tx_out = 1'b1;
        if (tx_en && baud_ok && st.tx_full && base_fall)
        begin
          next_st.tx_sh   = tx_data;
          next_st.tx_par  = (par_mode == PAR_ODD) ? ~^tx_data : ((par_mode == PAR_EVEN) ? ^tx_data : 1'b0);
          next_st.tx_full = 1'b0;
          next_st.tx_busy = 1'b1;
          next_st.tx_out  = 1'b0;
          next_st.tx_rst  = 1'b1;
          next_st.tx_st   = TX_START;
        end
      end
      TX_START:
      begin
        if (tx_t.tick)
        begin
          next_st.tx_out = st.tx_sh[0];
          next_st.tx_sh  = {1'b1, st.tx_sh[7:1]};
          next_st.tx_cnt = BIT_FIRST;
          next_st.tx_st  = TX_DATA;
        end
      end
      TX_DATA:
      begin
        if (tx_t.tick)
        begin
          if (st.tx_cnt == last_bit)
          begin
            next_st.tx_out = (par_mode == PAR_NONE) ? 1'b1 : st.tx_par;
            next_st.tx_st  = (par_mode == PAR_NONE) ? TX_STOP1 : TX_PAR;
          end
          else
          begin
            next_st.tx_out = st.tx_sh[0];
            next_st.tx_sh  = {1'b1, st.tx_sh[7:1]};
            next_st.tx_cnt = st.tx_cnt + BIT_STEP;
          end
        end
      end
      TX_PAR:
      begin
        if (tx_t.tick)
        begin
          next_st.tx_out = 1'b1;
          next_st.tx_st  = TX_STOP1;
        end
      end
      TX_STOP1, TX_STOP2:
      begin
        if (tx_t.tick && (st.tx_st == TX_STOP1) && st.mode[MODE_SL])
          next_st.tx_st = TX_STOP2;
        else if (tx_t.tick)
        begin
          next_st.tx_done = 1'b1;
          if (st.tx_full)
          begin
            // next byte moves in the same cycle the completion pulse is raised
            next_st.tx_sh   = tx_data;
            next_st.tx_par  = (par_mode == PAR_ODD) ? ~^tx_data : ((par_mode == PAR_EVEN) ? ^tx_data : 1'b0);
            next_st.tx_full = 1'b0;
            next_st.tx_out  = 1'b0;
            next_st.tx_rst  = 1'b1;
            next_st.tx_st   = TX_START;
          end
          else
          begin
            next_st.tx_busy = 1'b0;
            next_st.tx_st   = TX_IDLE;
          end
        end
      end
      default: next_st.tx_st = TX_IDLE;
    endcase

    // receiver
    case (st.rx_st)
      RX_IDLE:
      begin
        if (rx_en && baud_ok && !rx_line)
        begin
          next_st.rx_rst  = 1'b1;
          next_st.rx_half = 1'b1;
          next_st.rx_st   = RX_START;
        end
      end
      RX_START:
      begin
        if (rx_t.tick)
        begin
          next_st.rx_cnt = BIT_FIRST;
          next_st.rx_par = 1'b0;
          next_st.rx_st  = rx_line ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA:
      begin
        if (rx_t.tick)
        begin
          next_st.rx_sh  = {rx_line, st.rx_sh[7:1]};
          next_st.rx_par = st.rx_par ^ rx_line;
          next_st.rx_cnt = st.rx_cnt + BIT_STEP;
          if (st.rx_cnt == last_bit)
            next_st.rx_st = (par_mode == PAR_NONE) ? RX_STOP : RX_PAR;
        end
      end
      RX_PAR:
      begin
        if (rx_t.tick)
        begin
          // zero parity bit is received but never judged
          next_st.rx_pe = ((par_mode == PAR_ODD) && !(st.rx_par ^ rx_line)) ||
                          ((par_mode == PAR_EVEN) && (st.rx_par ^ rx_line));
          next_st.rx_st = RX_STOP;
        end
      end
      RX_STOP:
      begin
        if (rx_t.tick)
        begin
          pe  = st.rx_pe && (par_mode != PAR_NONE);
          fe  = !rx_line;
          ovr = st.rx_full;
          if (!st.rx_full)
          begin
            next_st.rxbuf   = rx_data;
            next_st.rx_full = 1'b1;
          end
          next_st.err[ERR_PE]  = next_st.err[ERR_PE] | pe;
          next_st.err[ERR_FE]  = next_st.err[ERR_FE] | fe;
          next_st.err[ERR_OVR] = next_st.err[ERR_OVR] | ovr;
          next_st.rx_bad = (pe || fe || ovr) && !st.mode[MODE_ROUTE];
          next_st.rx_ok  = !(pe || fe || ovr) || st.mode[MODE_ROUTE];
          next_st.rx_pe  = 1'b0;
          next_st.rx_st  = RX_IDLE;
        end
      end
      default: next_st.rx_st = RX_IDLE;
    endcase

    // disabled directions are held idle with pulses cleared; rxbuf, rx_full and err clear only at power off
    if (!tx_en)
    begin
      next_st.tx_st   = TX_IDLE;
      next_st.tx_out  = 1'b1;
      next_st.tx_full = 1'b0;
      next_st.tx_busy = 1'b0;
      next_st.tx_done = 1'b0;
    end
    if (!rx_en)
    begin
      next_st.rx_st  = RX_IDLE;
      next_st.rx_pe  = 1'b0;
      next_st.rx_ok  = 1'b0;
      next_st.rx_bad = 1'b0;
    end
    if (!power)
    begin
      next_st.age     = AGE_ZERO;
      next_st.err     = ERR_RST;
      next_st.aux     = next_st.aux & ~AUX_BREAK_MASK;
      next_st.rxbuf   = RXBUF_RST;
      next_st.rx_full = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= ST_RST;
    else
      st <= next_st;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_txbuf_write_full;
    wr_txbuf && tx_en && !st.tx_full |=> st.tx_full;
  endproperty
  a_txbuf_write_full: assert property (p_txbuf_write_full) else $error("buffer write did not set full");

  property p_power_off_line;
    !power |=> serial_out_pin;
  endproperty
  a_power_off_line: assert property (p_power_off_line) else $error("output not high with power off");

  property p_power_off_clear;
    !power |=> (st.err == ERR_RST) && !st.tx_full && !st.tx_busy && (st.rxbuf == RXBUF_RST) &&
               ((st.aux & AUX_BREAK_MASK) == AUX_RST);
  endproperty
  a_power_off_clear: assert property (p_power_off_clear) else $error("power off did not clear state");

  property p_load_on_fall;
    $rose(st.tx_busy) |-> $past(base_fall);
  endproperty
  a_load_on_fall: assert property (p_load_on_fall) else $error("shifter loaded off a base fall");

  property p_zero_parity_no_pe;
    $rose(st.err[ERR_PE]) |-> (par_mode == PAR_ODD) || (par_mode == PAR_EVEN);
  endproperty
  a_zero_parity_no_pe: assert property (p_zero_parity_no_pe) else $error("parity error outside odd or even");

  property p_overrun_keeps;
    rx_stop_tick && st.rx_full |=> $stable(st.rxbuf) && st.err[ERR_OVR];
  endproperty
  a_overrun_keeps: assert property (p_overrun_keeps) else $error("overrun overwrote buffer");

  property p_err_read_clear;
    err_rd && !rx_stop_tick |=> (st.err == ERR_RST);
  endproperty
  a_err_read_clear: assert property (p_err_read_clear) else $error("error read did not clear flags");

  property p_route_error;
    rx_error_irq |-> !$past(st.mode[MODE_ROUTE]) && !rx_complete_irq;
  endproperty
  a_route_error: assert property (p_route_error) else $error("error pulse with wrong routing");

  property p_baud_gate;
    tx_t.tick || rx_t.tick |-> baud_ok && power;
  endproperty
  a_baud_gate: assert property (p_baud_gate) else $error("bit tick before second base clock");

  property p_seven_bit;
    rx_stop_tick && !st.rx_full && !st.mode[MODE_CL] |=> !st.rxbuf[7];
  endproperty
  a_seven_bit: assert property (p_seven_bit) else $error("seven bit byte has top bit set");

  c_tx_done: cover property (tx_complete_irq);
  c_rx_ok:   cover property (rx_complete_irq);
  c_overrun: cover property ($rose(st.err[ERR_OVR]));
  c_parity:  cover property ($rose(st.err[ERR_PE]));
endmodule

// ==== ast_node.sv ====
// remote serial node model: frame sender and line sampler
`timescale 1ns/100ps
module ast_node #(
  parameter int BIT = 32
) (
  input  wire logic   ref_clk,
  input  wire logic   line_in,
  output logic        line_out,
  output logic [10:0] got,
  output int unsigned n_got
);
  initial
  begin
    line_out = 1'b1;
    got      = '0;
    n_got    = 0;
  end
  // eleven slots after start cover the longest frame; mid-bit sampling
  always
  begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 11; i++)
    begin
      repeat (BIT) @(posedge ref_clk);
      got[i] <= line_in;
    end
    n_got <= n_got + 1;
  end
  // start bit, then slots lsb first; trailing ones keep the line idle high
  task automatic send(input logic [10:0] f);
    for (int i = -1; i < 11; i++)
    begin
      @(posedge ref_clk);
      line_out <= (i < 0) ? 1'b0 : f[i];
      repeat (BIT - 1) @(posedge ref_clk);
    end
  endtask
endmodule

// ==== async_serial_txrx_core_bench.sv ====
// self-checking bench: apb master, base clock, remote node, format sweep
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module async_serial_txrx_core_bench
  import ast_pkg::*;
;
  logic              ref_clk  = 1'b0;
  logic              rst_n    = 1'b0;
  logic              psel     = 1'b0;
  logic              penable  = 1'b0;
  logic              pwrite   = 1'b0;
  logic [ADDR_W-1:0] paddr    = '0;
  logic [DATA_W-1:0] pwdata   = '0;
  logic              base_clk = 1'b0;
  logic [1:0]        bcnt     = 2'b00;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              rx_line;
  logic              tx_line;
  logic              tx_done;
  logic              rx_done;
  logic              rx_bad;
  logic [10:0]       got;
  int unsigned       n_got;
  logic [7:0]        q;
  logic              slv;
  logic [1:0]        irq;
  int                err_total = 0;
  int                compares  = 0;
  always #12.5 ref_clk = ~ref_clk;
  // base clock four ref cycles long, so a divisor of 8 gives 32-cycle bits
  always @(posedge ref_clk)
  begin
    bcnt     <= bcnt + 2'b01;
    base_clk <= bcnt[1];
  end
  ast_core ast_core_inst (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .base_clk(base_clk),
    .serial_in_pin(rx_line), .serial_out_pin(tx_line), .tx_complete_irq(tx_done), .rx_complete_irq(rx_done),
    .rx_error_irq(rx_bad));
  ast_node ast_node_inst (.ref_clk(ref_clk), .line_in(tx_line), .line_out(rx_line), .got(got), .n_got(n_got));
  task automatic stop_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {RD_PAD, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata[7:0];
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rx(input logic [10:0] f);
    irq = 2'b00;
    fork
      ast_node_inst.send(f);
      for (int i = 0; i < 1000 && irq == 2'b00; i++)
      begin
        @(posedge ref_clk);
        irq = {rx_bad, rx_done};
      end
    join
  endtask
  function automatic logic [10:0] frame(input logic [7:0] d, input logic [1:0] par, input logic cl);
    logic [10:0] f;
    logic        p;
    f = {3'b111, cl ? d[7] : 1'b1, d[6:0]};
    p = ^{cl & d[7], d[6:0]};
    if (par != PAR_NONE)
      f[7 + cl] = (par == PAR_ZERO) ? 1'b0 : (par[0] ? p : ~p);
    return f;
  endfunction
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
  end
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    stop_test();
  end
  initial
  begin
    logic [7:0]  d;
    logic [7:0]  prev;
    logic [10:0] f;
    logic [1:0]  par;
    logic        cl;
    logic        sl;
    logic        rt;
    int          s;
    int          k;
    int unsigned w;
    prev = TXBUF_RST;
    void'($urandom(14174));
    repeat (4) @(posedge ref_clk);
    apb(1'b0, ADDR_MODE, 8'h00);
    `CHK("mode rst", MODE_RST, q)
    apb(1'b0, ADDR_ERR, 8'h00);
    `CHK("err rst", ERR_RST, q)
    apb(1'b0, ADDR_TXBUF, 8'h00);
    `CHK("txbuf rst", TXBUF_RST, q)
    apb(1'b0, 18'h00000, 8'h00);
    `CHK("unmapped", 1'b1, slv)
    apb(1'b1, ADDR_BAUD, 8'h08);
    for (int i = 0; i < 8; i++)
    begin
      par = i[1:0];
      cl = i[2];
      sl = 1'($urandom);
      rt = 1'($urandom);
      d = 8'($urandom);
      s = 7 + cl + (par != PAR_NONE);
      apb(1'b1, ADDR_MODE, {3'b100, par, cl, sl, rt});
      repeat (8) @(posedge ref_clk);
      apb(1'b1, ADDR_MODE, {3'b111, par, cl, sl, rt});
      if (d == prev)
        d = ~d;
      prev = d;
      w = n_got;
      apb(1'b1, ADDR_TXBUF, d);
      for (k = 0; k < 1000 && tx_done !== 1'b1; k++)
        @(posedge ref_clk);
      `CHK("tx bits", 2 + s + sl, (k + 16) / 32)
      for (int j = 0; j < 2000 && n_got == w; j++)
        @(posedge ref_clk);
      `CHK("tx frame", frame(d, par, cl), got)
      apb(1'b0, ADDR_TXSTAT, 8'h00);
      `CHK("txstat", 8'h00, q)
      rx(frame(d, par, cl));
      `CHK("rx irq", 2'b01, irq)
      apb(1'b0, ADDR_ERR, 8'h00);
      `CHK("rx err", 8'h00, q)
      apb(1'b0, ADDR_RXBUF, 8'h00);
      `CHK("rxbuf", {cl & d[7], d[6:0]}, q)
      f = frame(d, par, cl);
      if (par == PAR_NONE)
        f[s] = 1'b0;
      else
        f[s - 1] = ~f[s - 1];
      rx(f);
      `CHK("bad irq", (par == PAR_ZERO || rt) ? 2'b01 : 2'b10, irq)
      apb(1'b0, ADDR_ERR, 8'h00);
      `CHK("bad err", {5'b00000, par[1], par == PAR_NONE, 1'b0}, q)
      apb(1'b0, ADDR_ERR, 8'h00);
      `CHK("err clr", 8'h00, q)
      apb(1'b0, ADDR_RXBUF, 8'h00);
      apb(1'b1, ADDR_MODE, {3'b100, par, cl, sl, rt});
    end
    apb(1'b1, ADDR_MODE, 8'hFF);
    rx(frame(d, PAR_EVEN, 1'b1));
    rx(frame(~d, PAR_EVEN, 1'b1));
    apb(1'b0, ADDR_ERR, 8'h00);
    `CHK("overrun", 8'h01, q)
    apb(1'b0, ADDR_RXBUF, 8'h00);
    `CHK("kept", d, q)
    rx(frame(~d, PAR_EVEN, 1'b1));
    // back to back bytes; the buffer still holds d, so ~d goes first to avoid a refresh
    apb(1'b1, ADDR_TXBUF, ~d);
    q = 8'h02;
    for (k = 0; k < 50 && q[1]; k++)
      apb(1'b0, ADDR_TXSTAT, 8'h00);
    `CHK("txstat busy", 8'h01, q)
    apb(1'b1, ADDR_TXBUF, d);
    for (k = 0; k < 1000 && tx_done !== 1'b1; k++)
      @(posedge ref_clk);
    `CHK("cont frame 1", frame(~d, PAR_EVEN, 1'b1), got)
    @(posedge ref_clk);
    for (k = 1; k < 1000 && tx_done !== 1'b1; k++)
      @(posedge ref_clk);
    // twelve bits of 32 cycles: next start follows the last stop directly
    `CHK("cont gap", 12 * 32, k)
    `CHK("cont frame 2", frame(d, PAR_EVEN, 1'b1), got)
    apb(1'b1, ADDR_MODE, 8'h9F);
    apb(1'b1, ADDR_MODE, 8'h00);
    repeat (4) @(posedge ref_clk);
    `CHK("off line", 1'b1, tx_line)
    apb(1'b0, ADDR_RXBUF, 8'h00);
    `CHK("off rxbuf", RXBUF_RST, q)
    stop_test();
  end
endmodule
